// *** design/dpll_pkg.sv ***
// Package for the dual synthesizer word decode and standby block.
// Assumes a single clk_sys domain; the reference clock arrives as a pin.
package dpll_pkg;

   // Frequency word field layout, most significant field first
   localparam int WORD_W      = 21;
   localparam int IDX_W       = 4;
   localparam int FB_W        = 7;
   localparam int ODIV_W      = 3;
   localparam int REFC_W      = 7;
   localparam int IDX_LSB     = 17;
   localparam int FB_LSB      = 10;
   localparam int ODIV_LSB    = 7;
   localparam int REFC_LSB    = 0;

   // Divide offsets applied to the programmed counts
   localparam logic [7:0] FB_OFFSET   = 8'h03;
   localparam logic [7:0] REFC_OFFSET = 8'h02;

   // Prescale factors chosen per frequency register
   localparam logic [2:0] PRESCALE_LO = 3'h2;
   localparam logic [2:0] PRESCALE_HI = 3'h4;

   // Index value that parks the video oscillator
   localparam logic [3:0] IDX_VIDEO_OFF = 4'hf;

   // Control word bit positions and reset
   localparam int CTRL_W              = 10;
   localparam int CTRL_MODE_SEL_BIT   = 9;
   localparam int CTRL_PRESCALE_REG0  = 0;
   localparam int CTRL_PRESCALE_REG1  = 1;
   localparam logic [9:0] CTRL_RESET  = 10'h020;

   // Standby divisor register
   localparam int SDIV_W              = 4;
   localparam logic [3:0] SDIV_RESET  = 4'h8;
   localparam logic [5:0] SDIV_BASE   = 6'h22;  // 34 - 2*value

   // Serial word address codes (3 bits)
   localparam int ADDR_W              = 3;
   localparam logic [2:0] ADDR_MEM    = 3'h3;
   localparam logic [2:0] ADDR_VIDEO  = 3'h0;
   localparam logic [2:0] ADDR_CTRL   = 3'h6;
   localparam logic [2:0] ADDR_SDIV   = 3'h4;
   localparam int SER_W               = 24;

   // Reset value of the frequency words
   localparam logic [20:0] WORD_RESET = 21'h000000;

   // Operating modes
   typedef enum logic [2:0] {
      DPLL_RUN    = 3'b001,
      DPLL_SLOW   = 3'b010,
      DPLL_HALT   = 3'b100
   } dpll_mode_t;

   // Decoded frequency word
   typedef struct packed {
      logic [3:0] index;
      logic [6:0] fb_count;
      logic [2:0] odiv_sel;
      logic [6:0] ref_count;
   } dpll_word_t;

   // Settings presented to one synthesizer
   typedef struct packed {
      logic [7:0] fb_div;
      logic [7:0] ref_div;
      logic [2:0] prescale;
      logic [7:0] out_div_log;
      logic       osc_enable;
   } dpll_synth_t;

endpackage

// *** design/dpll_slow_div.sv ***
// Slow memory clock divider used in standby mode one.
// Assumes ref_tick is a one-cycle pulse per reference clock rising edge.
`timescale 1ns/100ps
module dpll_slow_div (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // Control
   input  wire logic       enable,
   input  wire logic       ref_tick,
   input  wire logic [3:0] divisor_code,
   // Output
   output logic            slow_clk
);

   logic [5:0] half_cnt;
   logic [5:0] divisor;

   // Divisor 32 down to 4 in steps of two; code zero treated as one
   always_comb begin
      if (divisor_code == 4'h0) begin
         divisor = 6'h20;
      end else begin
         divisor = dpll_pkg::SDIV_BASE - {1'b0, divisor_code, 1'b0};
      end
   end

   // Toggle every half divisor; even divisors give 50% duty
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         half_cnt <= 6'h00;
         slow_clk <= 1'b0;
      end else if (!enable) begin
         half_cnt <= 6'h00;
         slow_clk <= 1'b0;
      end else if (ref_tick) begin
         if (half_cnt >= (divisor >> 1) - 6'h01) begin
            half_cnt <= 6'h00;
            slow_clk <= ~slow_clk;
         end else begin
            half_cnt <= half_cnt + 6'h01;
         end
      end
   end

endmodule // dpll_slow_div

// *** design/dpll_word_standby.sv ***
// Frequency word decode and standby control for two synthesizers.
// Assumes the serial shifter outside delivers a full 24-bit word with a
// one-cycle load strobe; the reference clock and standby pin are pins.
`timescale 1ns/100ps
// Contract
// - Word is index 4, feedback 7, output select 3, reference 7, MSB first.
// - Feedback divide is field plus three; reference divide is field plus two.
// - Prescale two or four, chosen per frequency register by control bits.
// - Output divide is two to the power of the select field.
// - Video index all ones stops video oscillator, muxes memory oscillator.
// - Other index values are stored but otherwise have no effect.
// - Standby one stops oscillators, video high, slow memory clock runs.
// - Standby one memory clock is reference over 32 down to 4.
// - Standby two disables all outputs, stops reference, keeps registers.
// - Standby pin high again resumes normal clock generation.
// - Control bit nine selects which standby mode the pin invokes.
// - Load strobe stores the shifted word into the addressed register.
module dpll_word_standby (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               reset_n,
   // Pins from outside
   input  wire logic               standby_request_n,
   input  wire logic               ref_clk_in,
   // Serial word load from the shifter
   input  wire logic               load_strobe,
   input  wire logic [23:0]        load_word,
   // Synthesizer settings
   output dpll_pkg::dpll_synth_t   mem_synth,
   output dpll_pkg::dpll_synth_t   video_synth,
   output logic                    video_from_mem,
   output logic                    ref_osc_enable,
   // Clock output controls
   output logic                    mem_clk_slow,
   output logic                    mem_use_slow,
   output logic                    mem_out_enable,
   output logic                    video_force_high,
   output logic                    video_out_enable,
   output dpll_pkg::dpll_mode_t    mode
);

   // Programmed registers, kept through both standby modes
   dpll_pkg::dpll_word_t  mem_word;
   dpll_pkg::dpll_word_t  video_word;
   logic [9:0]            control_word;
   logic [3:0]            standby_divisor;
   logic [1:0]            pd_sync;
   logic [1:0]            ref_sync;
   logic                  ref_prev;
   logic                  ref_tick;
   logic                  slow_clk;
   dpll_pkg::dpll_mode_t  next_mode;

   // Expand one word into synthesizer settings
   function automatic dpll_pkg::dpll_synth_t decode_word(
      input dpll_pkg::dpll_word_t w,
      input logic                 pre_hi,
      input logic                 osc_on);
      dpll_pkg::dpll_synth_t s;
      s.fb_div      = {1'b0, w.fb_count} + dpll_pkg::FB_OFFSET;
      s.ref_div     = {1'b0, w.ref_count} + dpll_pkg::REFC_OFFSET;
      s.prescale    = pre_hi ? dpll_pkg::PRESCALE_HI
                             : dpll_pkg::PRESCALE_LO;
      s.out_div_log = 8'h01 << w.odiv_sel;
      s.osc_enable  = osc_on;
      return s;
   endfunction

   // Only the all-ones index means anything; other values are just kept
   function automatic logic video_parked(
      input dpll_pkg::dpll_word_t w);
      return w.index == dpll_pkg::IDX_VIDEO_OFF;
   endfunction

   // Two-flop synchronisers for the pins
   // Standby sync resets high so no false standby follows reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pd_sync  <= 2'h3;
         ref_sync <= 2'h0;
         ref_prev <= 1'b0;
      end else begin
         pd_sync  <= {pd_sync[0], standby_request_n};
         ref_sync <= {ref_sync[0], ref_clk_in};
         ref_prev <= ref_sync[1];
      end
   end

   // Reference rising edge as an enable pulse
   assign ref_tick = ref_sync[1] & ~ref_prev;

   // Register loads; contents survive every standby mode
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_word        <= dpll_pkg::WORD_RESET;
         video_word      <= dpll_pkg::WORD_RESET;
         control_word    <= dpll_pkg::CTRL_RESET;
         standby_divisor <= dpll_pkg::SDIV_RESET;
      end else if (load_strobe) begin
         case (load_word[2:0])
            dpll_pkg::ADDR_MEM:   mem_word   <= load_word[23:3];
            dpll_pkg::ADDR_VIDEO: video_word <= load_word[23:3];
            dpll_pkg::ADDR_CTRL:  control_word <= load_word[12:3];
            dpll_pkg::ADDR_SDIV:  standby_divisor <= load_word[6:3];
            default: begin
            end
         endcase
      end
   end

   // Mode follows the pin; control bit nine picks the standby flavour
   // Pin and select decoded together so every pair has one outcome
   always_comb begin
      next_mode = dpll_pkg::DPLL_RUN;
      case ({pd_sync[1], control_word[dpll_pkg::CTRL_MODE_SEL_BIT]})
         2'h0: begin
            next_mode = dpll_pkg::DPLL_SLOW;
         end
         2'h1: begin
            next_mode = dpll_pkg::DPLL_HALT;
         end
         2'h2, 2'h3: begin
            next_mode = dpll_pkg::DPLL_RUN;
         end
         default: begin
            next_mode = dpll_pkg::DPLL_RUN;
         end
      endcase
   end

   // Mode register; a stray code falls back to running clocks
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode <= dpll_pkg::DPLL_RUN;
      end else begin
         case (next_mode)
            dpll_pkg::DPLL_RUN, dpll_pkg::DPLL_SLOW,
            dpll_pkg::DPLL_HALT: begin
               mode <= next_mode;
            end
            default: begin
               mode <= dpll_pkg::DPLL_RUN;
            end
         endcase
      end
   end

   // Memory synthesizer; its oscillator stops in either standby mode
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_synth <= '0;
      end else begin
         mem_synth <= decode_word(mem_word,
            control_word[dpll_pkg::CTRL_PRESCALE_REG1],
            next_mode == dpll_pkg::DPLL_RUN);
      end
   end

   // Video synthesizer; a parked index clears only osc_enable, all dividers still decoded; its output divider,
   // which is then fed from the memory oscillator instead
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         video_synth    <= '0;
         video_from_mem <= 1'b0;
      end else begin
         video_synth <= decode_word(video_word,
            control_word[dpll_pkg::CTRL_PRESCALE_REG0],
            next_mode == dpll_pkg::DPLL_RUN
            && !video_parked(video_word));
         video_from_mem <= video_parked(video_word);
      end
   end

   // Halt gates every output and the reference oscillator; registers
   // are untouched so clocks come back at their programmed rates
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ref_osc_enable   <= 1'b1;
         mem_out_enable   <= 1'b1;
         video_out_enable <= 1'b1;
      end else begin
         ref_osc_enable   <= next_mode != dpll_pkg::DPLL_HALT;
         mem_out_enable   <= next_mode != dpll_pkg::DPLL_HALT;
         video_out_enable <= next_mode != dpll_pkg::DPLL_HALT;
      end
   end

   // Standby one: memory output takes the slow clock, video held high
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_use_slow     <= 1'b0;
         video_force_high <= 1'b0;
      end else begin
         mem_use_slow     <= next_mode == dpll_pkg::DPLL_SLOW;
         video_force_high <= next_mode == dpll_pkg::DPLL_SLOW;
      end
   end

   // Slow clock level re-registered so the port comes from a flop
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_clk_slow <= 1'b0;
      end else begin
         mem_clk_slow <= slow_clk;
      end
   end

   // Slow refresh clock, gated off outside standby one; it restarts
   // low on entry so the first slow period is a whole one
   dpll_slow_div dpll_slow_div_inst (
      .clk_sys      (clk_sys),
      .reset_n      (reset_n),
      .enable       (mode == dpll_pkg::DPLL_SLOW),
      .ref_tick     (ref_tick),
      .divisor_code (standby_divisor),
      .slow_clk     (slow_clk)
   );

endmodule // dpll_word_standby

// *** test/dpll_word_standby_monitor.sv ***
// Port checker for the word decode and standby block.
// Assumes it is bound to the top module; one clk_sys domain.
`timescale 1ns/100ps
module dpll_word_standby_monitor (
   // Clock and reset
   input wire logic            clk_sys,
   input wire logic            reset_n,
   // Inputs seen
   input wire logic            standby_request_n,
   input wire logic            load_strobe,
   input wire logic [23:0]     load_word,
   // Outputs watched
   input dpll_pkg::dpll_synth_t mem_synth,
   input wire logic            video_from_mem,
   input wire logic            ref_osc_enable,
   input wire logic            mem_use_slow,
   input wire logic            mem_out_enable,
   input wire logic            video_force_high,
   input wire logic            video_out_enable,
   input dpll_pkg::dpll_mode_t mode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Loads of the memory and video words
   wire mld = load_strobe && load_word[2:0] == 3'h3;
   wire vld = load_strobe && load_word[2:0] == 3'h0;
   // A lone load shows on the synth outputs two edges on
   a_mem_feedback: assert property (mld ##1 !mld |=>
      mem_synth.fb_div == {1'b0, $past(load_word[19:13], 2)} + 8'h03)
      else $error("memory feedback divide wrong");
   a_mem_reference: assert property (mld ##1 !mld |=>
      mem_synth.ref_div == {1'b0, $past(load_word[9:3], 2)} + 8'h02)
      else $error("memory reference divide wrong");
   a_mem_out_div: assert property (mld ##1 !mld |=>
      mem_synth.out_div_log == 8'h01 << $past(load_word[12:10], 2))
      else $error("memory output divisor wrong");
   a_video_park: assert property (vld ##1 !vld |=>
      video_from_mem == ($past(load_word[23:20], 2) == 4'hf))
      else $error("video park flag wrong");
   a_halt_outputs: assert property (mode == dpll_pkg::DPLL_HALT |->
      !ref_osc_enable && !mem_out_enable && !video_out_enable)
      else $error("outputs live in halt mode");
   a_slow_outputs: assert property (mode == dpll_pkg::DPLL_SLOW |->
      mem_use_slow && video_force_high && mem_out_enable)
      else $error("slow mode outputs wrong");
   a_run_clean: assert property (mode == dpll_pkg::DPLL_RUN |->
      ref_osc_enable && video_out_enable && !mem_use_slow && !video_force_high)
      else $error("run mode outputs wrong");
   a_pin_resume: assert property (standby_request_n [*3] |=>
      mode == dpll_pkg::DPLL_RUN)
      else $error("no resume after pin high");
   // Main scenarios reached
   c_slow: cover property (mode == dpll_pkg::DPLL_SLOW);
   c_halt: cover property (mode == dpll_pkg::DPLL_HALT);
   c_park: cover property (video_from_mem);
endmodule // dpll_word_standby_monitor

// *** test/dpll_host_model.sv ***
// Controller-side stand-in: reference oscillator and standby pin.
// Assumes the bench commands the pin; released pin reads high.
`timescale 1ns/100ps
module dpll_host_model (
   // Command from the bench
   input  wire logic pull_low,
   // Pins toward the block
   output logic      ref_clk_in,
   output logic      standby_request_n
);
   // Free reference, 40 ns period, phase unrelated to clk_sys
   initial begin
      ref_clk_in = 1'b0;
      // Offset keeps reference edges off the clk_sys rising edges
      #3;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   // Pull-up wins whenever the controller lets go
   assign standby_request_n = pull_low ? 1'b0 : 1'b1;
endmodule // dpll_host_model

// *** test/dpll_word_standby_test.sv ***
// Self-checking bench for the word decode and standby block.
// Assumes the monitor and host model are compiled first.
`timescale 1ns/100ps
module dpll_word_standby_test;
   logic clk_sys = 1'b0, reset_n = 1'b0, pull_low = 1'b0;
   logic load_strobe = 1'b0;
   logic [23:0] load_word = 24'h000000;
   logic ref_clk_in, standby_request_n, video_from_mem, ref_osc_enable;
   logic mem_clk_slow, mem_use_slow, mem_out_enable, video_force_high;
   logic video_out_enable;
   dpll_pkg::dpll_synth_t mem_synth, video_synth;
   dpll_pkg::dpll_mode_t mode;
   int err_total = 0, total_checks = 0;
   time t0;
   logic [7:0] seed = 8'h5c;
   logic [20:0] w;
   logic [2:0] n_addr [4] = '{3'h1, 3'h2, 3'h5, 3'h7};
   initial forever #4 clk_sys = ~clk_sys;
   dpll_word_standby dpll_word_standby_inst (
      .clk_sys           (clk_sys),
      .reset_n           (reset_n),
      .standby_request_n (standby_request_n),
      .ref_clk_in        (ref_clk_in),
      .load_strobe       (load_strobe),
      .load_word         (load_word),
      .mem_synth         (mem_synth),
      .video_synth       (video_synth),
      .video_from_mem    (video_from_mem),
      .ref_osc_enable    (ref_osc_enable),
      .mem_clk_slow      (mem_clk_slow),
      .mem_use_slow      (mem_use_slow),
      .mem_out_enable    (mem_out_enable),
      .video_force_high  (video_force_high),
      .video_out_enable  (video_out_enable),
      .mode              (mode)
   );
   dpll_host_model dpll_host_model_inst (
      .pull_low          (pull_low),
      .ref_clk_in        (ref_clk_in),
      .standby_request_n (standby_request_n)
   );
   // Pseudo-random byte, fixed start
   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Slow clock period may jitter a cycle through the pin sync
   task automatic chk_near(int got, int exp);
      total_checks++;
      if (got < exp - 1 || got > exp + 1) begin
         err_total++;
         $display("BAD %0t period %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic chk_syn(dpll_pkg::dpll_synth_t s, logic [20:0] d, logic hi);
      chk(s.fb_div, {1'b0, d[16:10]} + 8'h03);
      chk(s.ref_div, {1'b0, d[6:0]} + 8'h02);
      chk(s.out_div_log, 8'h01 << d[9:7]);
      chk({5'h00, s.prescale}, hi ? 8'h04 : 8'h02);
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   // One load strobe, then one idle edge so the outputs settle
   task automatic load(logic [2:0] a, logic [20:0] d);
      cyc(1);
      load_strobe = 1'b1;
      load_word = {d, a};
      cyc(1);
      load_strobe = 1'b0;
      cyc(1);
   endtask
   task automatic slow_chk(logic [3:0] c);
      load(3'h4, {17'h00000, c});
      repeat (2) @(posedge mem_clk_slow);
      t0 = $time;
      @(posedge mem_clk_slow);
      chk_near(int'(($time - t0) / 8), (34 - 2 * c) * 5);
   endtask
   task automatic chk_mode(dpll_pkg::dpll_mode_t m);
      cyc(4);
      chk({5'h00, mode}, {5'h00, m});
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard, far beyond the few thousand cycles needed
   initial begin
      #400000;
      err_total++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      chk_mode(dpll_pkg::DPLL_RUN);
      // Random words with all-zero, all-ones and parked corners
      for (int i = 0; i < 32; i++) begin
         w = i == 0 ? 21'h000000 : i == 1 ? 21'h1fffff : 21'({rnd(), rnd(), rnd()});
         if (i == 5) w[20:17] = 4'hf;
         // 25 MHz reference, video prescale two (memory four), 10 over 5: 100 MHz in band
         if (i == 2) w = {4'h0, 7'h07, 3'h0, 7'h03};
         load(3'h6, 21'(i & 3));
         load(3'h3, w);
         load(3'h0, w);
         chk_syn(mem_synth, w, i[1]);
         chk_syn(video_synth, w, i[0]);
         chk({7'h00, video_synth.osc_enable}, {7'h00, w[20:17] != 4'hf});
         chk({7'h00, video_from_mem}, {7'h00, w[20:17] == 4'hf});
      end
      // Unmapped addresses leave both words alone
      foreach (n_addr[k]) load(n_addr[k], ~w);
      chk_syn(mem_synth, w, 1'b1);
      chk_syn(video_synth, w, 1'b1);
      // Slow standby: select bit cleared before the pin drops
      load(3'h6, 21'h000000);
      pull_low = 1'b1;
      chk_mode(dpll_pkg::DPLL_SLOW);
      chk({6'h00, mem_synth.osc_enable, video_synth.osc_enable}, 8'h00);
      slow_chk(4'h1);
      slow_chk(4'hf);
      slow_chk(4'h8);
      slow_chk(4'(rnd()) | 4'h1);
      pull_low = 1'b0;
      chk_mode(dpll_pkg::DPLL_RUN);
      // Halt standby keeps the programmed words
      load(3'h6, 21'h000200);
      pull_low = 1'b1;
      chk_mode(dpll_pkg::DPLL_HALT);
      chk({5'h00, ref_osc_enable, mem_out_enable, video_out_enable}, 8'h00);
      pull_low = 1'b0;
      chk_mode(dpll_pkg::DPLL_RUN);
      chk_syn(mem_synth, w, 1'b0);
      finish_test();
   end
endmodule // dpll_word_standby_test
bind dpll_word_standby dpll_word_standby_monitor
   dpll_word_standby_monitor_inst (
   .clk_sys           (clk_sys),
   .reset_n           (reset_n),
   .standby_request_n (standby_request_n),
   .load_strobe       (load_strobe),
   .load_word         (load_word),
   .mem_synth         (mem_synth),
   .video_from_mem    (video_from_mem),
   .ref_osc_enable    (ref_osc_enable),
   .mem_use_slow      (mem_use_slow),
   .mem_out_enable    (mem_out_enable),
   .video_force_high  (video_force_high),
   .video_out_enable  (video_out_enable),
   .mode              (mode)
);
